//--- hmsc_exec.sv
/*
 * execution logic for halt, no-operation, move to word mark, load with
 * defining mark, and store control register.
 * assumes a decoder delivers extracted operands and a one-cycle-read memory.
 */
// Function
// - plain halt stops; run resumes in sequence
// - halt-branch: sequence to b, a to sequence
// - ident halt leaves operands in address registers
// - variant halt captures variant character
// - peripheral transfer continues during halt
// - no-op leaves a and b registers, skips to mark
// - no-op loads last character into variant
// - move copies data and item marks
// - move stops at mark, registers decremented
// - move clears unmatched item, keeps word
// - load copies all punctuation through mark
// - load clears unmatched destination punctuation
// - store writes variant-selected register at units
// - short store uses retained variant
// - two-character mode stores 12 bits
// - three-character mode stores 15, zero three
// - four-character mode pads 18 or 19
// - uninstalled address bits stored as zero
// - small variants keep top character
// - a-register select stores prior value
`timescale 1ns/10ps
`default_nettype none
`include "hmsc_cfg.svh"

module hmsc_exec
    import hmsc_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    // instruction issue
    input  wire instr_t            instr_i,
    input  wire logic [1:0]        amode_i,
    input  wire logic              large_variant_i,
    input  wire logic [`REG_W-1:0] inst_mask_i,
    input  wire logic              run_i,
    input  wire logic [`REG_W-1:0] ctrl_reg_val_i,
    input  wire logic              periph_busy_i,
    // memory
    output mem_req_t               mem_req_o,
    input  wire char_t             mem_rdata_i,
    // register file
    output addr_t                  seq_o,
    output addr_t                  a_operand_addr_reg_o,
    output addr_t                  b_addr_o,
    output logic [5:0]             variant_o,
    output logic [5:0]             ctrl_sel_o,
    // status
    output logic                   halted_o,
    output logic                   busy_o,
    output logic                   periph_go_o
);

    typedef struct packed {
        exec_state_t st;
        logic [2:0]  op;
        addr_t       seq;
        addr_t       a_addr;
        addr_t       b_addr;
        logic [5:0]  var_ch;
        char_t       a_char;
        logic [2:0]  pos;
        logic [`REG_W-1:0] sc_val;
        logic        last_mark;
        mem_req_t    mem;
        logic        run_s1;
        logic        run_s2;
        logic        run_s3;
        logic        halted;
        logic        busy;
        logic        periph;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic [5:0] sc_data;
    logic       sc_last;

    function automatic logic is_mark(input char_t c);
        is_mark = c[`CH_WM_BIT];
    endfunction : is_mark

    hmsc_ctrl_store_fmt u_fmt (
        .amode_i         (amode_i),
        .large_variant_i (large_variant_i),
        .pos_i           (state_reg.pos),
        .value_i         (state_reg.sc_val),
        .inst_mask_i     (inst_mask_i),
        .old_char_i      (mem_rdata_i),
        .data_o          (sc_data),
        .last_o          (sc_last)
    );

    always_comb begin
        state_next        = state_reg;
        state_next.run_s1 = run_i;
        state_next.run_s2 = state_reg.run_s1;
        state_next.run_s3 = state_reg.run_s2;
        state_next.mem.rd = 1'b0;
        state_next.mem.wr = 1'b0;
        state_next.periph = periph_busy_i;
        unique case (state_reg.st)
            ST_IDLE: begin
                state_next.busy = 1'b0;
                if (instr_i.valid) begin
                    state_next.busy = 1'b1;
                    state_next.op   = instr_i.opcode;
                    if (instr_i.has_a && instr_i.opcode != `OP_NOP) begin
                        state_next.a_addr = instr_i.a_opnd;
                    end
                    if (instr_i.has_b && instr_i.opcode != `OP_NOP) begin
                        state_next.b_addr = instr_i.b_opnd;
                    end
                    unique case (instr_i.opcode)
                        `OP_HALT: begin
                            state_next.st     = ST_HALTED;
                            state_next.halted = 1'b1;
                            if (instr_i.halt_fmt == `HALT_FMT_BRANCH) begin
                                state_next.b_addr = state_reg.seq;
                                state_next.seq    = instr_i.a_opnd;
                            end
                            if (instr_i.halt_fmt == `HALT_FMT_IDVAR) begin
                                state_next.var_ch = instr_i.var_char;
                            end
                        end
                        `OP_NOP: begin
                            state_next.var_ch = instr_i.var_char;
                            state_next.mem.rd = 1'b1;
                            state_next.mem.addr = state_reg.seq;
                            state_next.st     = ST_SKIP;
                        end
                        `OP_STORE_CTRL: begin
                            if (instr_i.has_var) begin
                                state_next.var_ch = instr_i.var_char;
                            end
                            // a-register as held before this instruction
                            state_next.sc_val   = state_reg.a_addr;
                            state_next.pos      = 3'h0;
                            // no read yet: the selection settles first
                            state_next.mem.addr = instr_i.has_a ? instr_i.a_opnd
                                                  : state_reg.a_addr;
                            state_next.st       = ST_SC_WR;
                        end
                        default: begin
                            state_next.mem.rd   = 1'b1;
                            state_next.mem.addr = instr_i.has_a ? instr_i.a_opnd
                                                  : state_reg.a_addr;
                            state_next.st       = ST_RD_A;
                        end
                    endcase
                end
            end
            ST_HALTED: begin
                if (state_reg.run_s2 && state_reg.run_s3) begin
                    state_next.halted = 1'b0;
                    state_next.st     = ST_DONE;
                end
            end
            ST_SKIP: begin
                // advance to next word-marked op code
                if (is_mark(mem_rdata_i)) begin
                    state_next.st = ST_DONE;
                end else begin
                    state_next.seq      = state_reg.seq + 1'b1;
                    state_next.mem.rd   = 1'b1;
                    state_next.mem.addr = state_reg.seq + 1'b1;
                end
            end
            ST_RD_A: begin
                state_next.a_char   = mem_rdata_i;
                state_next.mem.rd   = 1'b1;
                state_next.mem.addr = state_reg.b_addr;
                state_next.st       = ST_RD_B;
            end
            ST_RD_B: begin
                state_next.mem.wr   = 1'b1;
                state_next.mem.addr = state_reg.b_addr;
                if (state_reg.op == `OP_MOVE_MARK) begin
                    state_next.mem.wdata = {state_reg.a_char[`CH_IM_BIT],
                                            mem_rdata_i[`CH_WM_BIT],
                                            state_reg.a_char[5:0]};
                    // mark in either field ends move
                    state_next.last_mark = is_mark(state_reg.a_char) ||
                                           is_mark(mem_rdata_i);
                end else begin
                    state_next.mem.wdata = state_reg.a_char;
                    state_next.last_mark = is_mark(state_reg.a_char);
                end
                state_next.st = ST_WR_B;
            end
            ST_WR_B: begin
                state_next.a_addr = state_reg.a_addr - 1'b1;
                state_next.b_addr = state_reg.b_addr - 1'b1;
                if (state_reg.last_mark) begin
                    state_next.st = ST_DONE;
                end else begin
                    state_next.mem.rd   = 1'b1;
                    state_next.mem.addr = state_reg.a_addr - 1'b1;
                    state_next.st       = ST_RD_A;
                end
            end
            ST_SC_WR: begin
                if (state_reg.mem.rd) begin
                    // read data in hand: write back at the same address
                    state_next.mem.wr    = 1'b1;
                    state_next.mem.wdata = {mem_rdata_i[7:6], sc_data};
                    state_next.pos       = state_reg.pos + 1'b1;
                    if (sc_last) begin
                        state_next.st = ST_DONE;
                    end
                end else if (state_reg.mem.wr) begin
                    state_next.mem.rd   = 1'b1;
                    state_next.mem.addr = state_reg.mem.addr - 1'b1;
                end else begin
                    // selection now follows the registered variant
                    state_next.sc_val = (state_reg.var_ch == `CREG_A_ADDR)
                                        ? state_reg.sc_val : ctrl_reg_val_i;
                    state_next.mem.rd = 1'b1;
                end
            end
            ST_DONE: begin
                state_next.busy = 1'b0;
                state_next.st   = ST_IDLE;
            end
            default: begin
                state_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign mem_req_o            = state_reg.mem;
    assign seq_o                = state_reg.seq;
    assign a_operand_addr_reg_o = state_reg.a_addr;
    assign b_addr_o             = state_reg.b_addr;
    assign variant_o            = state_reg.var_ch;
    assign ctrl_sel_o           = state_reg.var_ch;
    assign halted_o             = state_reg.halted;
    assign busy_o               = state_reg.busy;
    assign periph_go_o          = state_reg.periph;

    // assertions
    a_halt_holds_regs: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_reg.st == ST_HALTED && state_next.st == ST_HALTED)
        |=> $stable(state_reg.a_addr) && $stable(state_reg.b_addr))
        else $error("address registers changed while halted");
    a_halt_resume_seq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        state_reg.halted |=> state_reg.halted || $stable(state_reg.seq))
        else $error("sequence changed on resume");
    a_branch_saves_seq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_reg.st == ST_IDLE && instr_i.valid && instr_i.opcode == `OP_HALT
         && instr_i.halt_fmt == `HALT_FMT_BRANCH)
        |=> state_reg.b_addr == $past(state_reg.seq) && state_reg.seq == $past(instr_i.a_opnd))
        else $error("halt branch wrong");
    a_var_capture: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_reg.st == ST_IDLE && instr_i.valid && instr_i.opcode == `OP_HALT
         && instr_i.halt_fmt == `HALT_FMT_IDVAR) |=> state_reg.var_ch == $past(instr_i.var_char))
        else $error("variant not captured");
    a_periph_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        periph_busy_i |=> state_reg.periph)
        else $error("transfer dropped");
    a_nop_no_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        state_reg.st == ST_SKIP |-> !state_reg.mem.wr && $stable(state_reg.a_addr))
        else $error("no-op touched state");
    a_move_keeps_wm: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_reg.st == ST_RD_B && state_reg.op == `OP_MOVE_MARK)
        |=> state_reg.mem.wdata[`CH_WM_BIT] == $past(mem_rdata_i[`CH_WM_BIT]))
        else $error("move altered word mark");
    a_step_down: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        state_reg.st == ST_WR_B |=> state_reg.a_addr == $past(state_reg.a_addr) - 1'b1)
        else $error("address not decremented");
    a_load_full: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_reg.st == ST_RD_B && state_reg.op == `OP_LOAD_MARK)
        |=> state_reg.mem.wdata == $past(state_reg.a_char))
        else $error("load punctuation wrong");

    c_halt_run: cover property (@(posedge clk_sys_i) state_reg.halted ##1 !state_reg.halted);
    c_move_done: cover property (@(posedge clk_sys_i)
        state_reg.st == ST_WR_B && state_reg.last_mark);
    c_store_done: cover property (@(posedge clk_sys_i) state_reg.st == ST_SC_WR && sc_last);

endmodule : hmsc_exec

`default_nettype wire

//--- hmsc_cfg.svh
/*
 * constants for the halt / move / store-control execution block:
 * opcodes, punctuation bit positions, addressing modes, control register numbers.
 * assumes inclusion by the package, the design modules and the bench.
 */
`ifndef HMSC_CFG_SVH
`define HMSC_CFG_SVH

// opcode codes presented by the decoder
`define OP_HALT          3'h1
`define OP_NOP           3'h2
`define OP_MOVE_MARK     3'h3
`define OP_LOAD_MARK     3'h4
`define OP_STORE_CTRL    3'h5

// halt formats
`define HALT_FMT_PLAIN   2'h0
`define HALT_FMT_BRANCH  2'h1
`define HALT_FMT_IDENT   2'h2
`define HALT_FMT_IDVAR   2'h3

// character layout: bits 5:0 data, 6 word mark, 7 item mark; record mark = both
`define CH_DATA_W        6
`define CH_WM_BIT        6
`define CH_IM_BIT        7

// addressing modes
`define AMODE_TWO        2'h0
`define AMODE_THREE      2'h1
`define AMODE_FOUR       2'h2

// address register width
`define ADDR_W           19
`define REG_W            19

// control register number selecting the a-operand address register
`define CREG_A_ADDR      6'h37

`endif

//--- hmsc_pkg.sv
/*
 * types for the halt / move / store-control execution block.
 * assumes hmsc_cfg.svh is on the include path.
 */
`include "hmsc_cfg.svh"

package hmsc_pkg;

    typedef logic [7:0]              char_t;
    typedef logic [`ADDR_W-1:0]      addr_t;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_HALTED  = 4'b0001,
        ST_SKIP    = 4'b0010,
        ST_RD_A    = 4'b0011,
        ST_RD_B    = 4'b0100,
        ST_WR_B    = 4'b0101,
        ST_SC_WR   = 4'b0110,
        ST_DONE    = 4'b0111
    } exec_state_t;

    // instruction issue from the decoder
    typedef struct packed {
        logic       valid;
        logic [2:0] opcode;
        logic [1:0] halt_fmt;
        logic       has_a;
        logic       has_b;
        logic       has_var;
        addr_t      a_opnd;
        addr_t      b_opnd;
        logic [5:0] var_char;
    } instr_t;

    // memory request
    typedef struct packed {
        logic  rd;
        logic  wr;
        addr_t addr;
        char_t wdata;
    } mem_req_t;

endpackage : hmsc_pkg

//--- hmsc_ctrl_store_fmt.sv
/*
 * formats one character of a control register store by addressing mode
 * and position within the field.
 * assumes the caller steps positions from the units character upward.
 */
`timescale 1ns/10ps
`default_nettype none
`include "hmsc_cfg.svh"

module hmsc_ctrl_store_fmt
    import hmsc_pkg::*;
(
    // selection
    input  wire logic [1:0]        amode_i,
    input  wire logic              large_variant_i,
    input  wire logic [2:0]        pos_i,
    input  wire logic [`REG_W-1:0] value_i,
    input  wire logic [`REG_W-1:0] inst_mask_i,
    input  wire char_t             old_char_i,
    // result
    output logic [5:0]             data_o,
    output logic                   last_o
);

    logic [23:0] padded;
    logic [5:0]  sel;

    // zero bits not needed for installed memory
    assign padded = {5'h00, value_i & inst_mask_i};
    assign sel    = padded[6*pos_i +: 6];

    always_comb begin
        data_o = sel;
        last_o = 1'b0;
        unique case (amode_i)
            `AMODE_TWO: begin
                last_o = (pos_i == 3'h1);
            end
            `AMODE_THREE: begin
                if (pos_i == 3'h2) begin
                    data_o = {3'h0, sel[2:0]};
                    last_o = 1'b1;
                end
            end
            default: begin
                last_o = (pos_i == 3'h3);
                if (pos_i == 3'h3) begin
                    // 18 bits, or 19 plus zeros
                    data_o = large_variant_i ? {5'h00, sel[0]} : old_char_i[5:0];
                end
            end
        endcase
    end

endmodule : hmsc_ctrl_store_fmt

`default_nettype wire

//--- hmsc_mem_model.sv
/*
 * main memory model for the execution block: 512 characters, read data
 * stands in the same cycle as the read request.
 * assumes the bench preloads and inspects mem directly.
 */
`timescale 1ns/10ps
`default_nettype none

module hmsc_mem_model
    import hmsc_pkg::*;
(
    // clock
    input  wire logic     clk_sys_i,
    // request and answer
    input  wire mem_req_t req_i,
    output char_t         rdata_o
);
    char_t mem [0:511];

    // idle cycles show a fixed pattern with no word mark, never stored data
    assign rdata_o = req_i.rd ? mem[req_i.addr[8:0]] : 8'ha5;

    always @(posedge clk_sys_i) begin
        if (req_i.wr) begin
            mem[req_i.addr[8:0]] <= req_i.wdata;
        end
    end
endmodule : hmsc_mem_model

`default_nettype wire

//--- hmsc_exec_tb_top.sv
/*
 * self-checking bench for the execution block: halts, no-op, moves, stores.
 * assumes hmsc_cfg.svh and hmsc_pkg are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "hmsc_cfg.svh"

module hmsc_exec_tb_top
    import hmsc_pkg::*;
;
    logic              clk_sys_i = 1'b0;
    logic              rst_n_i = 1'b0;
    instr_t            instr_i = '0;
    logic [1:0]        amode_i = `AMODE_THREE;
    logic              large_variant_i = 1'b0;
    logic [`REG_W-1:0] inst_mask_i = 19'h7ffff;
    logic              run_i = 1'b0;
    logic              periph_busy_i = 1'b0;
    mem_req_t          mem_req_o;
    char_t             mem_rdata_i;
    addr_t             seq_o;
    addr_t             a_reg;
    addr_t             b_addr_o;
    logic [5:0]        variant_o;
    logic [5:0]        ctrl_sel_o;
    logic              halted_o;
    logic              busy_o;
    logic              periph_go_o;
    logic [`REG_W-1:0] ctrl_reg_val_i;
    int                bad_count = 0;
    int                checks = 0;
    addr_t             pa;
    addr_t             pb;

    // control memory stand-in: value depends on the selection
    assign ctrl_reg_val_i = {ctrl_sel_o, ctrl_sel_o, ctrl_sel_o, 1'b1};

    always #20 clk_sys_i = ~clk_sys_i;

    hmsc_exec u_hmsc_exec (
        .clk_sys_i            (clk_sys_i),
        .rst_n_i              (rst_n_i),
        .instr_i              (instr_i),
        .amode_i              (amode_i),
        .large_variant_i      (large_variant_i),
        .inst_mask_i          (inst_mask_i),
        .run_i                (run_i),
        .ctrl_reg_val_i       (ctrl_reg_val_i),
        .periph_busy_i        (periph_busy_i),
        .mem_req_o            (mem_req_o),
        .mem_rdata_i          (mem_rdata_i),
        .seq_o                (seq_o),
        .a_operand_addr_reg_o (a_reg),
        .b_addr_o             (b_addr_o),
        .variant_o            (variant_o),
        .ctrl_sel_o           (ctrl_sel_o),
        .halted_o             (halted_o),
        .busy_o               (busy_o),
        .periph_go_o          (periph_go_o)
    );

    hmsc_mem_model u_hmsc_mem_model (
        .clk_sys_i (clk_sys_i),
        .req_i     (mem_req_o),
        .rdata_o   (mem_rdata_i)
    );

    task automatic tally_and_finish;
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // halted high, or busy low when want_halt is clear
    task automatic wait_for(input logic want_halt);
        int n;
        n = 0;
        while ((want_halt ? halted_o !== 1'b1 : busy_o !== 1'b0) && n < 2000) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n >= 2000) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : wait_for

    task automatic go(input instr_t ins);
        @(negedge clk_sys_i);
        instr_i = ins;
        @(negedge clk_sys_i);
        instr_i.valid = 1'b0;
    endtask : go

    task automatic release_run;
        run_i = 1'b1;
        wait_for(1'b0);
        run_i = 1'b0;
    endtask : release_run

    function automatic instr_t mk(input logic [2:0] op, input logic [1:0] fmt, input addr_t a,
                                  input addr_t b, input logic [5:0] v, input logic [2:0] has);
        mk = '{1'b1, op, fmt, has[2], has[1], has[0], a, b, v};
    endfunction : mk

    task automatic store(input logic [1:0] am, input logic lg, input logic [18:0] mask,
                         input logic [5:0] v, input logic hv, input logic [18:0] val);
        logic [23:0] f;
        int          nb;
        for (int k = 0; k < 4; k++) begin
            u_hmsc_mem_model.mem[9'h1f0 - k] = 8'hff;
        end
        amode_i = am;
        large_variant_i = lg;
        inst_mask_i = mask;
        go(mk(`OP_STORE_CTRL, 2'h0, 19'h001f0, 19'h00000, v, {1'b1, 1'b0, hv}));
        wait_for(1'b0);
        f = {5'h00, val & mask};
        nb = (am == `AMODE_TWO) ? 2 : ((am == `AMODE_THREE || !lg) ? 3 : 4);
        if (am == `AMODE_TWO) begin
            f[23:12] = 12'h000;
        end else if (am == `AMODE_THREE) begin
            f[23:15] = 9'h000;
        end else if (!lg) begin
            f[23:18] = 6'h00;
        end
        for (int k = 0; k < 4; k++) begin
            chk("store char", {16'h0000, (k < nb) ? {2'b11, f[6*k +: 6]} : 8'hff},
                {16'h0000, u_hmsc_mem_model.mem[9'h1f0 - k]});
        end
    endtask : store

    initial begin
        repeat (6) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        pa = a_reg;
        pb = b_addr_o;
        periph_busy_i = 1'b1;
        go(mk(`OP_HALT, `HALT_FMT_PLAIN, 19'h00000, 19'h00000, 6'h00, 3'b000));
        wait_for(1'b1);
        repeat (3) @(negedge clk_sys_i);
        chk("periph go", 24'h1, {23'h0, periph_go_o});
        release_run();
        periph_busy_i = 1'b0;
        chk("a after halt", {5'h00, pa}, {5'h00, a_reg});
        chk("b after halt", {5'h00, pb}, {5'h00, b_addr_o});
        go(mk(`OP_HALT, `HALT_FMT_IDVAR, 19'h00123, 19'h00456, 6'h2b, 3'b111));
        wait_for(1'b1);
        chk("ident a", 24'h000123, {5'h00, a_reg});
        chk("ident b", 24'h000456, {5'h00, b_addr_o});
        chk("variant", 24'h00002b, {18'h0, variant_o});
        release_run();
        pa = seq_o;
        go(mk(`OP_HALT, `HALT_FMT_BRANCH, 19'h00789, 19'h00000, 6'h00, 3'b100));
        wait_for(1'b1);
        chk("branch b", {5'h00, pa}, {5'h00, b_addr_o});
        chk("branch seq", 24'h000789, {5'h00, seq_o});
        release_run();
        pa = a_reg;
        pb = b_addr_o;
        u_hmsc_mem_model.mem[seq_o[8:0]] = 8'h00;
        u_hmsc_mem_model.mem[seq_o[8:0] + 9'h1] = 8'h40;
        go(mk(`OP_NOP, 2'h0, 19'h00111, 19'h00222, 6'h15, 3'b111));
        wait_for(1'b0);
        chk("nop a", {5'h00, pa}, {5'h00, a_reg});
        chk("nop b", {5'h00, pb}, {5'h00, b_addr_o});
        chk("nop variant", 24'h000015, {18'h0, variant_o});
        chk("nop seq", 24'h00078a, {5'h00, seq_o});
        u_hmsc_mem_model.mem[100] = 8'h91;
        u_hmsc_mem_model.mem[99] = 8'h22;
        u_hmsc_mem_model.mem[98] = 8'h33;
        u_hmsc_mem_model.mem[97] = 8'h44;
        u_hmsc_mem_model.mem[200] = 8'h05;
        u_hmsc_mem_model.mem[199] = 8'h86;
        u_hmsc_mem_model.mem[198] = 8'h47;
        u_hmsc_mem_model.mem[197] = 8'h3f;
        go(mk(`OP_MOVE_MARK, 2'h0, 19'h00064, 19'h000c8, 6'h00, 3'b110));
        wait_for(1'b0);
        chk("move 200", 24'h91, {16'h0, u_hmsc_mem_model.mem[200]});
        chk("move 199", 24'h22, {16'h0, u_hmsc_mem_model.mem[199]});
        chk("move 198", 24'h73, {16'h0, u_hmsc_mem_model.mem[198]});
        chk("move 197", 24'h3f, {16'h0, u_hmsc_mem_model.mem[197]});
        chk("move a", 24'h000061, {5'h00, a_reg});
        chk("move b", 24'h0000c5, {5'h00, b_addr_o});
        u_hmsc_mem_model.mem[300] = 8'h81;
        u_hmsc_mem_model.mem[299] = 8'h42;
        u_hmsc_mem_model.mem[400] = 8'h45;
        u_hmsc_mem_model.mem[399] = 8'hc0;
        u_hmsc_mem_model.mem[398] = 8'h2a;
        go(mk(`OP_LOAD_MARK, 2'h0, 19'h0012c, 19'h00190, 6'h00, 3'b110));
        wait_for(1'b0);
        chk("load 400", 24'h81, {16'h0, u_hmsc_mem_model.mem[400]});
        chk("load 399", 24'h42, {16'h0, u_hmsc_mem_model.mem[399]});
        chk("load 398", 24'h2a, {16'h0, u_hmsc_mem_model.mem[398]});
        chk("load a", 24'h00012a, {5'h00, a_reg});
        chk("load b", 24'h00018e, {5'h00, b_addr_o});
        store(`AMODE_TWO, 1'b0, 19'h7ffff, 6'h2b, 1'b1, {6'h2b, 6'h2b, 6'h2b, 1'b1});
        store(`AMODE_THREE, 1'b0, 19'h7ffff, 6'h2b, 1'b1, {6'h2b, 6'h2b, 6'h2b, 1'b1});
        store(`AMODE_FOUR, 1'b0, 19'h7ffff, 6'h00, 1'b0, {6'h2b, 6'h2b, 6'h2b, 1'b1});
        store(`AMODE_FOUR, 1'b1, 19'h7ffff, 6'h2b, 1'b1, {6'h2b, 6'h2b, 6'h2b, 1'b1});
        store(`AMODE_FOUR, 1'b1, 19'h00fff, 6'h2b, 1'b1, {6'h2b, 6'h2b, 6'h2b, 1'b1});
        go(mk(`OP_HALT, `HALT_FMT_IDENT, 19'h00abc, 19'h00def, 6'h00, 3'b110));
        wait_for(1'b1);
        release_run();
        store(`AMODE_FOUR, 1'b1, 19'h7ffff, `CREG_A_ADDR, 1'b1, 19'h00abc);
        tally_and_finish();
    end
endmodule : hmsc_exec_tb_top

`default_nettype wire
